// ---- inc/pca_defines.svh ----
/*
  Bit positions, reset values and rates for the counter array.
  Assumes inclusion by bare name from the design files.
*/
`ifndef PCA_DEFINES_SVH
`define PCA_DEFINES_SVH
// Mode register fields
`define PCA_MODE_IRQ_EN 0
`define PCA_MODE_PWM 1
`define PCA_MODE_TOG 2
`define PCA_MODE_MAT 3
`define PCA_MODE_FALLING_CAPTURE_EN 4
`define PCA_MODE_RISING_CAPTURE_EN 5
`define PCA_MODE_COMPARATOR_ENABLE 6
`define PCA_MODE_RESET 8'h00
// Control register fields
`define PCA_CTL_CF 7
`define PCA_CTL_CR 6
`define PCA_CTL_RESET 8'h00
// Counter mode register fields
`define PCA_COUNTER_MODE_REG_IDL 7
`define PCA_COUNTER_MODE_REG_WATCHDOG_ENABLE 6
`define PCA_COUNTER_MODE_REG_SRC_HI 2
`define PCA_COUNTER_MODE_REG_SRC_LO 1
`define PCA_COUNTER_MODE_REG_ECF 0
`define PCA_COUNTER_MODE_REG_RESET 8'h00
// Internal count dividers, 6-clock and 12-clock modes
`define PCA_DIV_SLOW_6 6
`define PCA_DIV_FAST_6 2
`define PCA_DIV_SLOW_12 12
`define PCA_DIV_FAST_12 4
`define PCA_NUM_MODULES 5
`define PCA_FIRST_PIN 3
`endif

// ---- inc/pca_pkg.sv ----
/*
  Types shared by the counter array design.
  Assumes the defines header is compiled first.
*/
`default_nettype none
package pca_pkg;
  // Count source selection
  typedef enum logic [1:0] {
    PCA_SRC_SLOW,
    PCA_SRC_FAST,
    PCA_SRC_TIMER0,
    PCA_SRC_EXT
  } pca_src_t;
endpackage : pca_pkg
`default_nettype wire

// ---- rtl/pca_sync.sv ----
/*
  Two flip-flop synchroniser with edge detection for one pin.
  Assumes the pin is asynchronous to i_clk.
*/
`default_nettype none
module pca_sync (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  // Pin and outputs
  input wire logic i_pin,
  output logic o_level,
  output logic o_rise,
  output logic o_fall
);
  logic meta;
  logic sync;
  logic last;

  // Synchronise then remember previous level
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      // Pins idle high on their pull-ups, so no false edge after reset
      meta <= 1'b1;
      sync <= 1'b1;
      last <= 1'b1;
    end else begin
      meta <= i_pin;
      sync <= meta;
      last <= sync;
    end
  end

  // Edge pulses on synchronised level only
  assign o_level = sync;
  assign o_rise = sync & ~last;
  assign o_fall = ~sync & last;
endmodule : pca_sync
`default_nettype wire

// ---- rtl/pca_module.sv ----
/*
  One capture/compare module of the counter array.
  Assumes the counter and edge pulses are on i_clk.
*/
`default_nettype none
`include "pca_defines.svh"
module pca_module (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  // Shared counter
  input wire logic [15:0] i_count,
  input wire logic i_tick,
  // Register access
  input wire logic [7:0] i_mode,
  input wire logic i_wr_low,
  input wire logic i_wr_high,
  input wire logic [7:0] i_wdata,
  // Pin edges
  input wire logic i_rise,
  input wire logic i_fall,
  // Results
  output logic [7:0] o_value_low,
  output logic [7:0] o_value_high,
  output logic o_event,
  output logic o_pin
);
  logic match;
  logic capture;
  logic [7:0] pwm_low;
  logic toggle_q;

  // Comparator and capture edge choice
  assign match = i_mode[`PCA_MODE_COMPARATOR_ENABLE] & i_tick & (i_count == {o_value_high, o_value_low});
  assign capture = (i_rise & i_mode[`PCA_MODE_RISING_CAPTURE_EN]) | (i_fall & i_mode[`PCA_MODE_FALLING_CAPTURE_EN]);
  assign o_event = capture | (match & i_mode[`PCA_MODE_MAT]);

  // Value bytes: software writes or capture of counter
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      o_value_low <= 8'h00;
      o_value_high <= 8'h00;
    end else if (capture) begin
      o_value_low <= i_count[7:0];
      o_value_high <= i_count[15:8];
    end else begin
      if (i_wr_low) o_value_low <= i_wdata;
      if (i_wr_high) o_value_high <= i_wdata;
    end
  end

  // Active duty byte reloaded at low byte wrap
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      pwm_low <= 8'h00;
    end else if (i_wr_low) begin
      pwm_low <= i_wdata;
    end else if (i_tick && i_count[7:0] == 8'hff) begin
      pwm_low <= o_value_high;
    end
  end

  // High speed output toggle
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      toggle_q <= 1'b0;
    end else if (match && i_mode[`PCA_MODE_TOG]) begin
      toggle_q <= ~toggle_q;
    end
  end

  // Pin: pwm compare or toggle level, registered
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      o_pin <= 1'b1;
    end else if (i_mode[`PCA_MODE_PWM] && i_mode[`PCA_MODE_COMPARATOR_ENABLE]) begin
      o_pin <= (i_count[7:0] >= pwm_low);
    end else begin
      o_pin <= ~toggle_q;
    end
  end
endmodule : pca_module
`default_nettype wire

// ---- rtl/pca_counter_array.sv ----
/*
  Programmable counter array: shared 16-bit counter and five modules.
  Assumes a byte-wide register port from the processor core on i_clk,
  with one-cycle write strobes per register, and pins on port 1.
*/
`default_nettype none
`include "pca_defines.svh"
module pca_counter_array #(
  parameter int NUM_MODULES = `PCA_NUM_MODULES
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  // Core status
  input wire logic i_idle,
  input wire logic i_clk12_mode,
  input wire logic i_timer0_ovf,
  // Control register
  input wire logic i_ctl_wr,
  input wire logic [7:0] i_ctl_wdata,
  output logic [7:0] o_ctl,
  // Counter mode register
  input wire logic i_counter_mode_reg_wr,
  input wire logic [7:0] i_counter_mode_reg_wdata,
  output logic [7:0] o_counter_mode_reg,
  // Counter bytes
  input wire logic i_cnt_low_wr,
  input wire logic i_cnt_high_wr,
  input wire logic [7:0] i_cnt_wdata,
  output logic [7:0] o_counter_low_byte,
  output logic [7:0] o_counter_high_byte,
  // Module registers, write strobe per module, shared data
  input wire logic [NUM_MODULES-1:0] i_mode_wr,
  input wire logic [NUM_MODULES-1:0] i_val_low_wr,
  input wire logic [NUM_MODULES-1:0] i_val_high_wr,
  input wire logic [7:0] i_mod_wdata,
  output logic [8*NUM_MODULES-1:0] o_mode,
  output logic [8*NUM_MODULES-1:0] o_value_low,
  output logic [8*NUM_MODULES-1:0] o_value_high,
  // Port 1 pins
  input wire logic [7:0] i_port1,
  output logic [7:0] o_port1,
  output logic [7:0] o_port1_oe,
  // Interrupt request and watchdog
  output logic o_irq,
  output logic o_watchdog_reset
);
  logic [15:0] count;
  logic tick;
  logic [3:0] div_cnt;
  logic [3:0] div_max;
  logic internal_tick;
  logic ext_rise;
  logic [NUM_MODULES-1:0] mod_rise;
  logic [NUM_MODULES-1:0] mod_fall;
  logic [NUM_MODULES-1:0] mod_event;
  logic [NUM_MODULES-1:0] mod_pin;
  logic [NUM_MODULES-1:0] irq_terms;
  logic running;
  logic ovf;
  pca_pkg::pca_src_t src;

  // Elaboration check on module count
  if (NUM_MODULES != `PCA_NUM_MODULES) begin : g_bad_count
    $error("counter array needs five modules");
  end

  // Mode-register helper used for every module
  function automatic logic [7:0] mode_of(input logic [8*NUM_MODULES-1:0] all, input int n);
    mode_of = all[8*n +: 8];
  endfunction : mode_of

  // Source field decode
  assign src = pca_pkg::pca_src_t'({o_counter_mode_reg[`PCA_COUNTER_MODE_REG_SRC_HI], o_counter_mode_reg[`PCA_COUNTER_MODE_REG_SRC_LO]});

  // Counter runs when enabled, held in idle when idle bit set
  assign running = o_ctl[`PCA_CTL_CR] & ~(i_idle & o_counter_mode_reg[`PCA_COUNTER_MODE_REG_IDL]);

  // Internal divider terminal count by source and clock mode
  always_comb begin
    if (src == pca_pkg::PCA_SRC_FAST) begin
      div_max = i_clk12_mode ? 4'(`PCA_DIV_FAST_12 - 1) : 4'(`PCA_DIV_FAST_6 - 1);
    end else begin
      div_max = i_clk12_mode ? 4'(`PCA_DIV_SLOW_12 - 1) : 4'(`PCA_DIV_SLOW_6 - 1);
    end
  end

  // Divider produces one-cycle enable
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      div_cnt <= 4'h0;
    end else if (div_cnt >= div_max) begin
      div_cnt <= 4'h0;
    end else begin
      div_cnt <= div_cnt + 4'h1;
    end
  end
  assign internal_tick = (div_cnt >= div_max);

  // External count input synchroniser on port1 bit 2
  pca_sync u_ext_sync (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_pin(i_port1[2]),
    .o_level(),
    .o_rise(ext_rise),
    .o_fall()
  );

  // Count pulse selection
  always_comb begin
    case (src)
      pca_pkg::PCA_SRC_SLOW: tick = internal_tick;
      pca_pkg::PCA_SRC_FAST: tick = internal_tick;
      pca_pkg::PCA_SRC_TIMER0: tick = i_timer0_ovf;
      pca_pkg::PCA_SRC_EXT: tick = ext_rise;
      default: tick = 1'b0;
    endcase
    tick = tick & running;
  end

  assign ovf = tick & (count == 16'hffff);

  // Shared counter, software may load its bytes
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      count <= 16'h0000;
    end else if (i_cnt_low_wr || i_cnt_high_wr) begin
      if (i_cnt_low_wr) count[7:0] <= i_cnt_wdata;
      if (i_cnt_high_wr) count[15:8] <= i_cnt_wdata;
    end else if (tick) begin
      count <= count + 16'h0001;
    end
  end
  assign o_counter_low_byte = count[7:0];
  assign o_counter_high_byte = count[15:8];

  // Counter mode register
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      o_counter_mode_reg <= `PCA_COUNTER_MODE_REG_RESET;
    end else if (i_counter_mode_reg_wr) begin
      o_counter_mode_reg <= i_counter_mode_reg_wdata & 8'hc7; // Reserved bits read zero
    end
  end

  // Control register: flags set by hardware win over software clear
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      o_ctl <= `PCA_CTL_RESET;
    end else begin
      if (i_ctl_wr) begin
        o_ctl <= i_ctl_wdata & 8'hdf;
      end
      if (ovf) o_ctl[`PCA_CTL_CF] <= 1'b1;
      for (int n = 0; n < NUM_MODULES; n++) begin
        if (mod_event[n]) o_ctl[n] <= 1'b1;
      end
    end
  end

  // Modules and their pins
  for (genvar n = 0; n < NUM_MODULES; n++) begin : g_mod
    always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
        o_mode[8*n +: 8] <= `PCA_MODE_RESET;
      end else if (i_mode_wr[n]) begin
        o_mode[8*n +: 8] <= i_mod_wdata & 8'h7f;
      end
    end

    pca_sync u_sync (
      .i_clk(i_clk),
      .i_reset(i_reset),
      .i_pin(i_port1[`PCA_FIRST_PIN + n]),
      .o_level(),
      .o_rise(mod_rise[n]),
      .o_fall(mod_fall[n])
    );

    pca_module u_mod (
      .i_clk(i_clk),
      .i_reset(i_reset),
      .i_count(count),
      .i_tick(tick),
      .i_mode(mode_of(o_mode, n)),
      .i_wr_low(i_val_low_wr[n]),
      .i_wr_high(i_val_high_wr[n]),
      .i_wdata(i_mod_wdata),
      .i_rise(mod_rise[n]),
      .i_fall(mod_fall[n]),
      .o_value_low(o_value_low[8*n +: 8]),
      .o_value_high(o_value_high[8*n +: 8]),
      .o_event(mod_event[n]),
      .o_pin(mod_pin[n])
    );

    // Interrupt per module flag
    assign irq_terms[n] = o_ctl[n] & o_mode[8*n + `PCA_MODE_IRQ_EN];
  end

  // Port 1 drive: module pins drive when compare output used
  always_comb begin
    o_port1 = 8'hff;
    o_port1_oe = 8'h00;
    for (int n = 0; n < NUM_MODULES; n++) begin
      o_port1[`PCA_FIRST_PIN + n] = mod_pin[n];
      o_port1_oe[`PCA_FIRST_PIN + n] = o_mode[8*n + `PCA_MODE_COMPARATOR_ENABLE] &
        (o_mode[8*n + `PCA_MODE_PWM] | o_mode[8*n + `PCA_MODE_TOG]);
    end
  end

  // Interrupt request
  assign o_irq = (o_ctl[`PCA_CTL_CF] & o_counter_mode_reg[`PCA_COUNTER_MODE_REG_ECF]) | (|irq_terms);

  // Watchdog: module 4 match resets when enabled
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      o_watchdog_reset <= 1'b0;
    end else begin
      o_watchdog_reset <= o_counter_mode_reg[`PCA_COUNTER_MODE_REG_WATCHDOG_ENABLE] & mod_event[NUM_MODULES-1] &
        o_mode[8*(NUM_MODULES-1) + `PCA_MODE_MAT];
    end
  end
endmodule : pca_counter_array
`default_nettype wire

// ---- testbench/pca_pin_model.sv ----
/*
  Port 1 pin model for the counter array: count input and capture pins.
  Assumes the bench sets i_ext_run and i_cap off the rising edge.
*/
`default_nettype none
module pca_pin_model (
  // Clock
  input wire logic i_clk,
  // Bench requests
  input wire logic i_ext_run,
  input wire logic [4:0] i_cap,
  // Design pin drive
  input wire logic [7:0] i_dut_out,
  input wire logic [7:0] i_dut_oe,
  // Resolved pins
  output logic [7:0] o_pins
);
  logic [1:0] div = 2'h0;
  logic ext = 1'h0;
  // Count pulses, one rise per 4 clocks, low between bursts
  always_ff @(negedge i_clk) begin
    div <= i_ext_run ? div + 2'h1 : 2'h0;
    ext <= i_ext_run && div[1];
  end
  // Pull-ups hold released lines high, design wins where it drives
  always_comb begin
    o_pins = 8'hff;
    o_pins[2] = ext;
    o_pins[7:3] = i_cap;
    for (int b = 0; b < 8; b++) begin
      if (i_dut_oe[b]) begin
        o_pins[b] = i_dut_out[b];
      end
    end
  end
endmodule : pca_pin_model
`default_nettype wire

// ---- testbench/pca_counter_array_props.sv ----
/*
  Port checker for the counter array.
  Assumes it is bound to the top module on one clock.
*/
`default_nettype none
module pca_counter_array_props #(
  parameter int NUM_MODULES = 5
) (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_ctl_wr,
  input wire logic [7:0] i_ctl_wdata,
  input wire logic i_cnt_low_wr,
  input wire logic i_cnt_high_wr,
  input wire logic [NUM_MODULES-1:0] i_mode_wr,
  input wire logic [7:0] i_mod_wdata,
  input wire logic [7:0] o_ctl,
  input wire logic [7:0] o_counter_mode_reg,
  input wire logic [7:0] o_counter_low_byte,
  input wire logic [7:0] o_counter_high_byte,
  input wire logic [8*NUM_MODULES-1:0] o_mode,
  input wire logic [7:0] o_port1_oe,
  input wire logic o_irq
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);
  wire logic [15:0] cnt = {o_counter_high_byte, o_counter_low_byte};
  wire logic nowr = !i_cnt_low_wr && !i_cnt_high_wr;
  logic [NUM_MODULES-1:0] irq_en;
  logic [NUM_MODULES-1:0] oe_exp;
  // Per-module interrupt enables and expected pin drive
  always_comb begin
    for (int n = 0; n < NUM_MODULES; n++) begin
      irq_en[n] = o_mode[8*n];
      oe_exp[n] = o_mode[8*n+6] && (o_mode[8*n+1] || o_mode[8*n+2]);
    end
  end
  sequence s_wrap;
    cnt == 16'hffff && nowr ##1 cnt == 16'h0000;
  endsequence
  sequence s_halted;
    (!o_ctl[6] && nowr) [*3];
  endsequence
  a_ovf_sticky: assert property (o_ctl[7] && !i_ctl_wr |=> o_ctl[7])
    else $error("overflow flag dropped without a write");
  a_flags_sticky: assert property (!i_ctl_wr |=> (o_ctl[4:0] & $past(o_ctl[4:0])) == $past(o_ctl[4:0]))
    else $error("module flag dropped without a write");
  a_stop_holds: assert property (s_halted |=> $stable(cnt))
    else $error("counter moved while stopped");
  a_step_one: assert property (nowr |=> cnt == $past(cnt) || cnt == $past(cnt) + 16'h0001)
    else $error("counter stepped by more than one");
  a_wrap_flag: assert property (s_wrap |-> ##[0:1] o_ctl[7])
    else $error("wrap did not set overflow flag");
  a_irq_cause: assert property (o_irq == ((o_ctl[7] && o_counter_mode_reg[0]) || |(o_ctl[4:0] & irq_en)))
    else $error("interrupt request disagrees with flags");
  a_run_write: assert property (i_ctl_wr |=> o_ctl[6] == $past(i_ctl_wdata[6]))
    else $error("run bit not taken from write");
  a_mode_write: assert property (i_mode_wr[0] |=> o_mode[6:0] == $past(i_mod_wdata[6:0]))
    else $error("mode bits not taken from write");
  a_pin_drive: assert property (o_port1_oe[7:3] == oe_exp && o_port1_oe[2:0] == 3'h0)
    else $error("pin drive disagrees with mode");
endmodule : pca_counter_array_props
bind pca_counter_array pca_counter_array_props #(.NUM_MODULES(NUM_MODULES)) u_props (.i_clk, .i_reset,
  .i_ctl_wr, .i_ctl_wdata, .i_cnt_low_wr, .i_cnt_high_wr, .i_mode_wr, .i_mod_wdata, .o_ctl, .o_counter_mode_reg,
  .o_counter_low_byte, .o_counter_high_byte, .o_mode, .o_port1_oe, .o_irq);
`default_nettype wire

// ---- testbench/pca_counter_array_test.sv ----
/*
  Self-checking bench for the counter array.
  Assumes the pin model and the bound checker are compiled alongside.
*/
`default_nettype none
`include "pca_defines.svh"
module pca_counter_array_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clk = 1'h0, i_reset = 1'h1, i_idle = 1'h0, i_clk12_mode = 1'h0, i_timer0_ovf = 1'h0;
  logic i_ctl_wr = 1'h0, i_counter_mode_reg_wr = 1'h0, i_cnt_low_wr = 1'h0, i_cnt_high_wr = 1'h0, ext_run = 1'h0;
  logic [4:0] i_mode_wr = 5'h00, i_val_low_wr = 5'h00, i_val_high_wr = 5'h00, cap = 5'h00;
  logic [7:0] wd = 8'h00, o_ctl, o_counter_mode_reg, lo, hi, o_p1, o_oe, pins;
  logic [39:0] o_mode, o_vl, o_vh;
  logic o_irq, wdog;
  int err_total = 0, n_compared = 0, n_wd = 0;
  wire logic [15:0] cnt = {hi, lo};
  always #12.5 i_clk = ~i_clk;
  pca_counter_array u_dut (.i_clk, .i_reset, .i_idle, .i_clk12_mode, .i_timer0_ovf, .i_ctl_wr,
    .i_ctl_wdata(wd), .o_ctl, .i_counter_mode_reg_wr, .i_counter_mode_reg_wdata(wd), .o_counter_mode_reg, .i_cnt_low_wr, .i_cnt_high_wr,
    .i_cnt_wdata(wd), .o_counter_low_byte(lo), .o_counter_high_byte(hi), .i_mode_wr, .i_val_low_wr,
    .i_val_high_wr, .i_mod_wdata(wd), .o_mode, .o_value_low(o_vl), .o_value_high(o_vh),
    .i_port1(pins), .o_port1(o_p1), .o_port1_oe(o_oe), .o_irq, .o_watchdog_reset(wdog));
  // Count watchdog pulses where they are settled
  always @(negedge i_clk) if (wdog === 1'b1) n_wd++;
  pca_pin_model u_pin (.i_clk, .i_ext_run(ext_run), .i_cap(cap), .i_dut_out(o_p1), .i_dut_oe(o_oe),
    .o_pins(pins));
  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : complete_run
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(negedge i_clk);
  endtask : cyc
  // Register write: 0 ctl, 1 counter_mode_reg, 2 count low, 3 count high, 4 mode, 5 value low, 6 value high
  task automatic wr(input int k, input int n, input logic [7:0] d);
    wd = d;
    case (k)
      0: i_ctl_wr = 1'h1;
      1: i_counter_mode_reg_wr = 1'h1;
      2: i_cnt_low_wr = 1'h1;
      3: i_cnt_high_wr = 1'h1;
      4: i_mode_wr[n] = 1'h1;
      5: i_val_low_wr[n] = 1'h1;
      default: i_val_high_wr[n] = 1'h1;
    endcase
    cyc(1);
    {i_ctl_wr, i_counter_mode_reg_wr, i_cnt_low_wr, i_cnt_high_wr} = 4'h0;
    {i_mode_wr, i_val_low_wr, i_val_high_wr} = 15'h0000;
    cyc(1);
  endtask : wr
  task automatic set_cnt(input logic [15:0] v);
    wr(2, 0, v[7:0]);
    wr(3, 0, v[15:8]);
  endtask : set_cnt
  task automatic delta(input logic [15:0] d, input int n, input string what);
    logic [15:0] c0;
    cyc(6);
    c0 = cnt;
    cyc(n);
    chk(what, c0 + d, cnt);
  endtask : delta
  task automatic t_source();
    logic [15:0] c0;
    for (int i = 0; i < 4; i++) begin
      i_clk12_mode = i[1];
      wr(1, 0, {6'h00, i[0], 1'h0});
      wr(0, 0, 8'h40);
      delta(16'h000a, 10 * (i[1] ? (i[0] ? `PCA_DIV_FAST_12 : `PCA_DIV_SLOW_12)
        : (i[0] ? `PCA_DIV_FAST_6 : `PCA_DIV_SLOW_6)), "internal rate");
      wr(0, 0, 8'h00);
    end
    i_clk12_mode = 1'h0;
    wr(1, 0, 8'h04);
    wr(0, 0, 8'h40);
    delta(16'h0000, 10, "timer0 idle");
    c0 = cnt;
    repeat (7) begin
      i_timer0_ovf = 1'h1;
      cyc(1);
      i_timer0_ovf = 1'h0;
      cyc(2);
    end
    delta(16'h0000, 4, "timer0 settle");
    chk("timer0 count", c0 + 16'h0007, cnt);
    wr(1, 0, 8'h06);
    ext_run = 1'h1;
    delta(16'h000a, 40, "external count");
    ext_run = 1'h0;
    wr(0, 0, 8'h00);
    $display("test sources done");
  endtask : t_source
  task automatic t_idle();
    wr(1, 0, 8'h82);
    wr(0, 0, 8'h40);
    i_idle = 1'h1;
    delta(16'h0000, 20, "idle stop");
    wr(1, 0, 8'h02);
    delta(16'h000a, 20, "idle run");
    i_idle = 1'h0;
    wr(0, 0, 8'h00);
    delta(16'h0000, 20, "halted");
    $display("test idle done");
  endtask : t_idle
  task automatic t_overflow();
    wr(1, 0, 8'h03);
    set_cnt(16'hfffe);
    wr(0, 0, 8'h40);
    cyc(12);
    chk("overflow flag", 16'h0001, o_ctl[7]);
    chk("overflow irq", 16'h0001, o_irq);
    cyc(20);
    chk("flag kept", 16'h0001, o_ctl[7]);
    wr(0, 0, 8'h00);
    chk("flag cleared", 16'h0000, {o_ctl, 7'h00, o_irq});
    $display("test overflow done");
  endtask : t_overflow
  task automatic t_watchdog();
    int w0;
    w0 = n_wd;
    wr(1, 0, 8'h42);
    set_cnt(16'h0000);
    wr(5, 4, 8'h08);
    wr(6, 4, 8'h00);
    wr(4, 4, 8'h48);
    wr(0, 0, 8'h40);
    cyc(30);
    wr(0, 0, 8'h00);
    chk("watchdog pulses", 16'h0001, 16'(n_wd - w0));
    wr(1, 0, 8'h02);
    set_cnt(16'h0000);
    wr(0, 0, 8'h40);
    cyc(30);
    wr(0, 0, 8'h00);
    chk("watchdog disabled", 16'h0001, 16'(n_wd - w0));
    $display("test watchdog done");
  endtask : t_watchdog
  task automatic t_match();
    set_cnt(16'h0000);
    wr(5, 0, 8'h10);
    wr(6, 0, 8'h00);
    wr(4, 0, 8'h4d);
    wr(0, 0, 8'h40);
    cyc(40);
    chk("match flag", 16'h0041, o_ctl);
    chk("toggled pin", 16'h0000, o_p1[3]);
    chk("match irq", 16'h0001, o_irq);
    wr(0, 0, 8'h00);
    $display("test match done");
  endtask : t_match
  task automatic cap_step(input logic [7:0] m, input logic lvl, input logic [15:0] exp);
    wr(4, 1, m);
    cap[1] = lvl;
    cyc(6);
    chk("captured value", exp, {o_vh[15:8], o_vl[15:8]});
  endtask : cap_step
  task automatic t_capture();
    set_cnt(16'h1234);
    cap_step(8'h20, 1'h1, 16'h1234);
    set_cnt(16'h5678);
    cap_step(8'h20, 1'h0, 16'h1234);
    cap_step(8'h30, 1'h1, 16'h5678);
    set_cnt(16'h9abc);
    cap_step(8'h10, 1'h0, 16'h9abc);
    chk("capture flag", 16'h0002, o_ctl);
    wr(0, 0, 8'h00);
    $display("test capture done");
  endtask : t_capture
  task automatic t_pwm();
    wr(5, 2, 8'h80);
    wr(6, 2, 8'h80);
    wr(4, 2, 8'h42);
    set_cnt(16'h007f);
    chk("pwm below", 16'h0000, o_p1[5]);
    set_cnt(16'h0080);
    chk("pwm at duty", 16'h0001, o_p1[5]);
    wr(6, 2, 8'h40);
    set_cnt(16'h00fd);
    wr(0, 0, 8'h40);
    cyc(12);
    wr(0, 0, 8'h00);
    set_cnt(16'h0050);
    chk("pwm reloaded", 16'h0001, o_p1[5]);
    $display("test pwm done");
  endtask : t_pwm
  // Watchdog against a hang
  initial begin
    repeat (6000) @(posedge i_clk);
    err_total++;
    complete_run();
  end
  // Main sequence
  initial begin
    cyc(5);
    i_reset = 1'h0;
    chk("reset control", 16'h0000, {o_ctl, o_counter_mode_reg});
    chk("reset pins", 16'h001f, o_p1[7:3]);
    t_source();
    t_idle();
    t_overflow();
    t_match();
    t_capture();
    t_pwm();
    t_watchdog();
    complete_run();
  end
endmodule : pca_counter_array_test
`default_nettype wire
